// ### design/sbsp_master.sv
// master end: turns single and burst commands into clocked memory pin cycles
`timescale 1ns/100ps
module sbsp_master #(
  parameter int ADDR_W = sbsp_pkg::SBSP_ADDR_W, // word address width
  parameter int DATA_W = sbsp_pkg::SBSP_DATA_W, // data width
  parameter int LANES = sbsp_pkg::SBSP_LANES // byte lanes
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset, active low
  sbsp_if.host bus, // pins to the memory
  input wire logic cmd_valid, // command offered
  output logic cmd_ready, // command taken this edge when valid
  input wire logic cmd_write, // 1 write, 0 read
  input wire logic cmd_burst, // 1 four beats, 0 single
  input wire logic cmd_global, // write all lanes
  input wire logic [LANES-1:0] cmd_lanes, // lanes to write, active high
  input wire logic [ADDR_W-1:0] cmd_addr, // start word address
  input wire logic [DATA_W-1:0] wr_data, // write beat data
  output logic wr_take, // write beat consumed this edge
  output logic [DATA_W-1:0] rd_data, // read beat data
  output logic rd_valid, // read beat pulse
  input wire logic mode_linear, // linear burst order
  input wire logic mode_pipeline, // registered read path
  input wire logic mode_drive, // 0 leaves mode pins open
  input wire logic sleep_req // ask memory to sleep
);
  import sbsp_pkg::*;

  sbsp_mstate_e state;
  sbsp_mstate_e next_state;
  logic [1:0] beat;
  logic [1:0] next_beat;
  logic cur_write;
  logic cur_global;
  logic [LANES-1:0] cur_lanes;
  logic [ADDR_W-1:0] p_addr;
  logic p_ce_n;
  logic p_processor_address_strobe_n;
  logic p_controller_address_strobe_n;
  logic p_adv_n;
  logic p_gw_n;
  logic p_bw_n;
  logic [LANES-1:0] p_lane_n;
  logic [DATA_W-1:0] p_wdata;
  logic p_woe;
  logic p_rd;
  logic p_g_n;
  logic p_zz;
  logic p_lbo_n;
  logic p_ft_n;
  logic p_drv;
  logic [1:0] pipe;
  logic accept;
  logic hit;
  logic [ADDR_W-1:0] next_addr;
  logic next_ce_n;
  logic next_processor_address_strobe_n;
  logic next_controller_address_strobe_n;
  logic next_adv_n;
  logic next_gw_n;
  logic next_bw_n;
  logic [LANES-1:0] next_lane_n;
  logic next_woe;
  logic next_rd;

  // a write waits until no read can still own the data lanes
  assign cmd_ready = (state == SBSP_M_IDLE) && !sleep_req && (!cmd_write || (pipe == 2'h0 && !p_rd));
  assign accept = cmd_valid && cmd_ready;
  assign wr_take = (accept && cmd_write) || (state == SBSP_M_BURST && cur_write);
  // pick the beat whose latency matches the mode pin actually seen by the memory;
  // with the mode pins left open the memory runs on its pull level, not on p_ft_n
  assign hit = (p_drv ? p_ft_n : SBSP_PULL_FT_N) ? pipe[1] : pipe[0];

  // pin sequencing: idle cycles are a strobe with chip enable off, i.e. a deselect
  always_comb
  begin
    next_state = state;
    next_beat = beat;
    next_addr = p_addr;
    next_ce_n = 1'b1;
    next_processor_address_strobe_n = 1'b1;
    next_controller_address_strobe_n = 1'b0;
    next_adv_n = 1'b1;
    next_gw_n = 1'b1;
    next_bw_n = 1'b1;
    next_lane_n = '1;
    next_woe = 1'b0;
    next_rd = 1'b0;
    unique case (state)
      SBSP_M_BURST:
      begin
        // following beats: no strobe, step the counter, address comes from inside
        next_ce_n = 1'b0;
        next_controller_address_strobe_n = 1'b1;
        next_adv_n = 1'b0;
        next_gw_n = !(cur_write && cur_global);
        next_bw_n = !(cur_write && !cur_global);
        next_lane_n = ~cur_lanes;
        next_woe = cur_write;
        next_rd = !cur_write;
        next_beat = 2'(beat + 1'b1);
        if (beat == SBSP_LAST_FOLLOW)
        begin
          next_state = SBSP_M_IDLE;
        end
      end
      SBSP_M_IDLE:
      begin
        if (accept)
        begin
          // reads start on the processor strobe, writes on the controller strobe
          next_addr = cmd_addr;
          next_ce_n = 1'b0;
          next_processor_address_strobe_n = cmd_write;
          next_controller_address_strobe_n = !cmd_write;
          next_gw_n = !(cmd_write && cmd_global);
          next_bw_n = !(cmd_write && !cmd_global);
          next_lane_n = ~cmd_lanes;
          next_woe = cmd_write;
          next_rd = !cmd_write;
          next_beat = 2'h0;
          if (cmd_burst)
          begin
            next_state = SBSP_M_BURST;
          end
        end
      end
      default:
      begin
        // unused state code: fall back to idle deselect
        next_state = SBSP_M_IDLE;
      end
    endcase
  end

  // every pin leaves a flop so it is stable around the memory's capturing edge
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= SBSP_M_IDLE;
      beat <= 2'h0;
      cur_write <= 1'b0;
      cur_global <= 1'b0;
      cur_lanes <= '0;
      p_addr <= '0;
      p_ce_n <= 1'b1;
      p_processor_address_strobe_n <= 1'b1;
      p_controller_address_strobe_n <= 1'b1;
      p_adv_n <= 1'b1;
      p_gw_n <= 1'b1;
      p_bw_n <= 1'b1;
      p_lane_n <= '1;
      p_wdata <= '0;
      p_woe <= 1'b0;
      p_rd <= 1'b0;
      p_g_n <= 1'b1;
      p_zz <= 1'b0;
      p_lbo_n <= 1'b1;
      p_ft_n <= 1'b1;
      p_drv <= 1'b0;
      pipe <= 2'h0;
      rd_data <= '0;
      rd_valid <= 1'b0;
    end
    else
    begin
      state <= next_state;
      beat <= next_beat;
      if (accept)
      begin
        cur_write <= cmd_write;
        cur_global <= cmd_global;
        cur_lanes <= cmd_lanes;
      end
      p_addr <= next_addr;
      p_ce_n <= next_ce_n;
      p_processor_address_strobe_n <= next_processor_address_strobe_n;
      p_controller_address_strobe_n <= next_controller_address_strobe_n;
      p_adv_n <= next_adv_n;
      p_gw_n <= next_gw_n;
      p_bw_n <= next_bw_n;
      p_lane_n <= next_lane_n;
      p_wdata <= wr_take ? wr_data : p_wdata;
      p_woe <= next_woe;
      p_rd <= next_rd;
      // enable outputs over the cycles where read data can be on the lanes
      p_g_n <= !(p_rd || pipe[0]);
      p_zz <= sleep_req && state == SBSP_M_IDLE && !accept;
      // changing modes with reads in flight mis-times the sampling
      p_lbo_n <= !mode_linear;
      p_ft_n <= mode_pipeline;
      p_drv <= mode_drive;
      pipe <= {pipe[0], p_rd};
      rd_valid <= hit;
      rd_data <= hit ? bus.dq : rd_data;
    end
  end

  assign bus.addr = p_addr;
  assign bus.chip_enable_one_n = p_ce_n;
  assign bus.processor_address_strobe_n = p_processor_address_strobe_n;
  assign bus.controller_address_strobe_n = p_controller_address_strobe_n;
  assign bus.burst_step_control_n = p_adv_n;
  assign bus.global_write_n = p_gw_n;
  assign bus.byte_group_write_enable_n = p_bw_n;
  assign bus.lane_write_select_n = p_lane_n;
  assign bus.output_drive_enable_n = p_g_n;
  assign bus.sleep_request = p_zz;
  assign bus.linear_order_select_n = p_lbo_n;
  assign bus.flow_through_select_n = p_ft_n;
  assign bus.mode_driven = p_drv;
  assign bus.dq_m_out = p_wdata;
  assign bus.dq_m_oe = p_woe;
endmodule

// ### design/sbsp_pkg.sv
// shared constants and types for the synchronous burst static memory port
package sbsp_pkg;
  // array geometry
  localparam int SBSP_ADDR_W = 19;
  localparam int SBSP_DATA_W = 36;
  localparam int SBSP_LANES = 4;
  // burst counter
  localparam int SBSP_CNT_W = 2;
  localparam int SBSP_BURST_LEN = 4;
  localparam logic [1:0] SBSP_LAST_FOLLOW = 2'h2;
  // read latency in clocks from the capturing edge
  localparam int SBSP_LAT_FLOW = 1;
  localparam int SBSP_LAT_PIPE = 2;
  // levels the internal resistors give a mode pin left open
  localparam logic SBSP_PULL_FT_N = 1'h1;
  localparam logic SBSP_PULL_LBO_N = 1'h1;
  localparam logic SBSP_PULL_SLEEP = 1'h0;
  // master sequencer states
  typedef enum logic [1:0] {
    SBSP_M_IDLE = 2'b00,
    SBSP_M_BURST = 2'b01
  } sbsp_mstate_e;
endpackage

// ### design/sbsp_if.sv
// pin-level interface between the burst memory and its master
`timescale 1ns/100ps
interface sbsp_if #(
  parameter int ADDR_W = sbsp_pkg::SBSP_ADDR_W,
  parameter int DATA_W = sbsp_pkg::SBSP_DATA_W,
  parameter int LANES = sbsp_pkg::SBSP_LANES
);
  logic [ADDR_W-1:0] addr;
  logic chip_enable_one_n;
  logic processor_address_strobe_n;
  logic controller_address_strobe_n;
  logic burst_step_control_n;
  logic global_write_n;
  logic byte_group_write_enable_n;
  logic [LANES-1:0] lane_write_select_n;
  logic output_drive_enable_n;
  logic sleep_request;
  logic linear_order_select_n;
  logic flow_through_select_n;
  logic mode_driven;
  logic [DATA_W-1:0] dq_m_out;
  logic dq_m_oe;
  logic [DATA_W-1:0] dq_d_out;
  logic dq_d_oe;
  logic [DATA_W-1:0] dq;

  // wire level of the shared data lanes; an undriven bus reads high
  assign dq = dq_d_oe ? dq_d_out : (dq_m_oe ? dq_m_out : '1);

  modport dev (
    input addr, chip_enable_one_n, processor_address_strobe_n, controller_address_strobe_n,
    input burst_step_control_n, global_write_n, byte_group_write_enable_n, lane_write_select_n,
    input output_drive_enable_n, sleep_request, linear_order_select_n, flow_through_select_n,
    input mode_driven, dq,
    output dq_d_out, dq_d_oe
  );
  modport host (
    output addr, chip_enable_one_n, processor_address_strobe_n, controller_address_strobe_n,
    output burst_step_control_n, global_write_n, byte_group_write_enable_n, lane_write_select_n,
    output output_drive_enable_n, sleep_request, linear_order_select_n, flow_through_select_n,
    output mode_driven, dq_m_out, dq_m_oe,
    input dq
  );
endinterface

// ### design/sbsp_sram.sv
// memory end: burst counter, storage, flow-through or pipelined read path
`timescale 1ns/100ps
module sbsp_sram #(
  parameter int ADDR_W = sbsp_pkg::SBSP_ADDR_W, // word address width
  parameter int DATA_W = sbsp_pkg::SBSP_DATA_W, // data width
  parameter int LANES = sbsp_pkg::SBSP_LANES // byte lanes
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset, active low
  sbsp_if.dev bus, // pins to the master
  output logic asleep, // sleep state, level
  output logic pipelined, // effective output register mode
  output logic [sbsp_pkg::SBSP_CNT_W-1:0] burst_lsbs // current burst low address bits
);
  import sbsp_pkg::*;

  localparam int LW = DATA_W / LANES;

  logic lbo_n;
  logic ft_n;
  logic zz;
  logic strobe;
  logic [LANES-1:0] wr_mask;
  logic access;
  logic sel;
  logic next_sel;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] next_base;
  logic [SBSP_CNT_W-1:0] start;
  logic [SBSP_CNT_W-1:0] next_start;
  logic [SBSP_CNT_W-1:0] step;
  logic [SBSP_CNT_W-1:0] next_step;
  logic [ADDR_W-1:0] acc_addr;
  logic [ADDR_W-1:0] acc_addr_q;
  logic acc_rd_q;
  logic next_acc_rd;
  logic acc_wr_q;
  logic next_acc_wr;
  logic rd2_q;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] out_q;
  logic drive;

  // internal resistors: an open mode pin reads its pulled level
  assign lbo_n = bus.mode_driven ? bus.linear_order_select_n : SBSP_PULL_LBO_N;
  assign ft_n = bus.mode_driven ? bus.flow_through_select_n : SBSP_PULL_FT_N;
  assign zz = bus.mode_driven ? bus.sleep_request : SBSP_PULL_SLEEP;
  // stopping the clock also idles the core; nothing here needs an edge to sleep
  assign asleep = zz;
  assign pipelined = ft_n;
  assign burst_lsbs = acc_addr_q[SBSP_CNT_W-1:0];

  // burst order of the low address bits
  function automatic logic [SBSP_CNT_W-1:0] order_lsbs(
    input logic lin_n,
    input logic [SBSP_CNT_W-1:0] s,
    input logic [SBSP_CNT_W-1:0] k
  );
    order_lsbs = lin_n ? (s ^ k) : SBSP_CNT_W'(s + k);
  endfunction

  // command decode and burst counter next state
  always_comb
  begin
    strobe = !bus.processor_address_strobe_n || !bus.controller_address_strobe_n;
    // global write overrides the byte-group controls
    if (!bus.global_write_n)
    begin
      wr_mask = '1;
    end
    else if (!bus.byte_group_write_enable_n)
    begin
      wr_mask = ~bus.lane_write_select_n;
    end
    else
    begin
      wr_mask = '0;
    end
    next_sel = sel;
    next_base = base;
    next_start = start;
    next_step = step;
    acc_addr = acc_addr_q;
    access = 1'b0;
    if (zz)
    begin
      // sleeping: commands ignored, array untouched
      next_sel = 1'b0;
    end
    else if (strobe && !bus.chip_enable_one_n)
    begin
      // a new address may land on any cycle, mid-burst included
      next_sel = 1'b1;
      next_base = bus.addr;
      next_start = bus.addr[SBSP_CNT_W-1:0];
      next_step = '0;
      acc_addr = bus.addr;
      access = 1'b1;
    end
    else if (strobe)
    begin
      next_sel = 1'b0;
    end
    else if (sel)
    begin
      if (!bus.burst_step_control_n)
      begin
        next_step = SBSP_CNT_W'(step + 1'b1);
      end
      acc_addr = {base[ADDR_W-1:SBSP_CNT_W], order_lsbs(lbo_n, start, next_step)};
      access = 1'b1;
    end
    next_acc_wr = access && (wr_mask != '0);
    next_acc_rd = access && (wr_mask == '0);
  end

  // input and burst registers, all loaded on the rising edge
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sel <= 1'b0;
      base <= '0;
      start <= '0;
      step <= '0;
      acc_addr_q <= '0;
      acc_rd_q <= 1'b0;
      acc_wr_q <= 1'b0;
      rd2_q <= 1'b0;
    end
    else
    begin
      sel <= next_sel;
      base <= next_base;
      start <= next_start;
      step <= next_step;
      acc_addr_q <= acc_addr;
      acc_rd_q <= next_acc_rd;
      acc_wr_q <= next_acc_wr;
      rd2_q <= acc_rd_q;
    end
  end

  // storage split per lane; writes complete at the capturing edge, no pulse needed
  for (genvar g = 0; g < LANES; g++)
  begin : g_lane
    logic [LW-1:0] lane_mem [2**ADDR_W];
    // no reset on the array: contents survive sleep and reset alike
    always_ff @(posedge clk_sys)
    begin
      if (access && wr_mask[g])
      begin
        lane_mem[acc_addr] <= bus.dq[g*LW +: LW];
      end
    end
    assign rd_word[g*LW +: LW] = lane_mem[acc_addr_q];
  end

  // data output register for pipelined mode
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_q <= '0;
    end
    else
    begin
      out_q <= rd_word;
    end
  end

  // read at E1 shows in flow-through from E1, pipelined from E2; in pipelined mode
  // a write captured at an edge stops the drive one stage sooner than a read or deselect
  always_comb
  begin
    if (ft_n)
    begin
      drive = rd2_q && !acc_wr_q;
    end
    else
    begin
      drive = acc_rd_q;
    end
  end

  // output enable and sleep gate the drivers combinationally
  assign bus.dq_d_oe = drive && !bus.output_drive_enable_n && !zz;
  assign bus.dq_d_out = ft_n ? out_q : rd_word;
endmodule

// ### bench/sbsp_checker.sv
// pin protocol assertions between the master and the memory end
`timescale 1ns/100ps
module sbsp_checker #(
  parameter int LANES = sbsp_pkg::SBSP_LANES // byte lanes
) (
  input logic clk_sys, // clock
  input logic rst_b, // reset, active low
  input logic chip_enable_one_n, // chip enable
  input logic processor_address_strobe_n, // strobe
  input logic controller_address_strobe_n, // strobe
  input logic burst_step_control_n, // counter step
  input logic global_write_n, // all lanes
  input logic byte_group_write_enable_n, // byte write
  input logic [LANES-1:0] lane_write_select_n, // lane selects
  input logic output_drive_enable_n, // async enable
  input logic sleep_request, // async sleep
  input logic flow_through_select_n, // read path
  input logic mode_driven, // mode pins driven
  input logic dq_d_oe // memory drives lanes
);
  import sbsp_pkg::*;
  logic slp;
  logic ft;
  logic strobe;
  logic wr;
  logic rd;
  logic desel;
  logic step;

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // open mode pins read as their pull levels
  assign slp = mode_driven ? sleep_request : SBSP_PULL_SLEEP;
  assign ft = mode_driven ? flow_through_select_n : SBSP_PULL_FT_N;
  // commands as the memory captures them; a byte write with no lane is a read
  assign strobe = !processor_address_strobe_n || !controller_address_strobe_n;
  assign wr = !slp && !chip_enable_one_n
    && (!global_write_n || (!byte_group_write_enable_n && !(&lane_write_select_n)));
  assign rd = !slp && strobe && !chip_enable_one_n && !wr;
  assign desel = !slp && strobe && chip_enable_one_n;
  assign step = !slp && !strobe && !chip_enable_one_n && !burst_step_control_n && !wr;

  a_sleep_quiet: assert property (slp |-> !dq_d_oe)
    else $error("lanes driven while asleep");
  a_oe_gate: assert property (output_drive_enable_n |-> !dq_d_oe)
    else $error("lanes driven with output enable off");
  a_flow_read: assert property ((rd && !ft) ##1 (!ft && !slp) |-> (output_drive_enable_n || dq_d_oe))
    else $error("flow-through read data late");
  a_pipe_read: assert property ((rd && ft) ##1 ft ##1 (ft && !slp) |-> (output_drive_enable_n || dq_d_oe))
    else $error("pipelined read data missing");
  a_flow_desel: assert property ((desel && !ft) |=> !dq_d_oe)
    else $error("flow-through drive after deselect");
  a_pipe_desel: assert property ((desel && ft) ##1 ft |=> !dq_d_oe)
    else $error("pipelined drive too long after deselect");
  a_write_quiet: assert property (wr |=> !dq_d_oe)
    else $error("lanes driven after a write");
  a_burst_drive: assert property ((rd && ft) ##1 step [*3] |-> (output_drive_enable_n || dq_d_oe) [*3])
    else $error("burst beats not driven");
endmodule

// ### bench/tb.sv
// self-checking bench: master and memory ends joined through the pin interface
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("ERROR at %0t: got %h, expected %h", $time, got, exp); \
    end \
  end
module tb;
  import sbsp_pkg::*;
  localparam int lane_w = SBSP_DATA_W / SBSP_LANES;
  logic clk_sys = 1'h0;
  logic rst_b = 1'h0;
  logic cmd_valid = 1'h0;
  logic cmd_ready;
  logic cmd_write = 1'h0;
  logic cmd_burst = 1'h0;
  logic cmd_global = 1'h0;
  logic [SBSP_LANES-1:0] cmd_lanes = '0;
  logic [SBSP_ADDR_W-1:0] cmd_addr = '0;
  logic [SBSP_DATA_W-1:0] wr_data = '0;
  logic wr_take;
  logic [SBSP_DATA_W-1:0] rd_data;
  logic rd_valid;
  logic mode_linear = 1'h1;
  logic mode_pipeline = 1'h1;
  logic mode_drive = 1'h1;
  logic sleep_req = 1'h0;
  logic asleep;
  logic pipelined;
  logic [SBSP_CNT_W-1:0] burst_lsbs;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [SBSP_DATA_W-1:0] mem [0:63];
  logic [SBSP_DATA_W-1:0] xq [$];
  int tq [$];
  logic [SBSP_DATA_W-1:0] exp_d;
  int exp_t;

  sbsp_if u_sbsp_if ();
  sbsp_master u_sbsp_master (.clk_sys(clk_sys), .rst_b(rst_b), .bus(u_sbsp_if.host), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_burst(cmd_burst), .cmd_global(cmd_global),
    .cmd_lanes(cmd_lanes), .cmd_addr(cmd_addr), .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data),
    .rd_valid(rd_valid), .mode_linear(mode_linear), .mode_pipeline(mode_pipeline), .mode_drive(mode_drive),
    .sleep_req(sleep_req));
  sbsp_sram u_sbsp_sram (.clk_sys(clk_sys), .rst_b(rst_b), .bus(u_sbsp_if.dev), .asleep(asleep),
    .pipelined(pipelined), .burst_lsbs(burst_lsbs));
  sbsp_checker #(.LANES(SBSP_LANES)) u_sbsp_checker (.clk_sys(clk_sys), .rst_b(rst_b),
    .chip_enable_one_n(u_sbsp_if.chip_enable_one_n),
    .processor_address_strobe_n(u_sbsp_if.processor_address_strobe_n),
    .controller_address_strobe_n(u_sbsp_if.controller_address_strobe_n),
    .burst_step_control_n(u_sbsp_if.burst_step_control_n), .global_write_n(u_sbsp_if.global_write_n),
    .byte_group_write_enable_n(u_sbsp_if.byte_group_write_enable_n),
    .lane_write_select_n(u_sbsp_if.lane_write_select_n), .output_drive_enable_n(u_sbsp_if.output_drive_enable_n),
    .sleep_request(u_sbsp_if.sleep_request), .flow_through_select_n(u_sbsp_if.flow_through_select_n),
    .mode_driven(u_sbsp_if.mode_driven), .dq_d_oe(u_sbsp_if.dq_d_oe));

  // free-running clock
  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end

  // edge count, used to pin down when each read beat must arrive
  always @(posedge clk_sys)
    cyc <= cyc + 1;

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic give_up();
    miscompares++;
    $display("ERROR at %0t: wait ran out", $time);
    report_and_stop();
  endtask

  // offer one command {write, burst, global}; keep leaves valid up for a back-to-back follower
  task automatic issue(input logic [2:0] f, input logic [SBSP_LANES-1:0] ln, input logic [SBSP_ADDR_W-1:0] a,
      input logic [SBSP_DATA_W-1:0] d, input bit keep);
    int n;
    int lat;
    logic lin;
    logic [SBSP_ADDR_W-1:0] ba;
    logic [SBSP_DATA_W-1:0] dk;
    n = 0;
    lin = mode_drive ? mode_linear : !SBSP_PULL_LBO_N;
    lat = (mode_drive ? mode_pipeline : SBSP_PULL_FT_N) ? SBSP_LAT_PIPE : SBSP_LAT_FLOW;
    cmd_valid <= 1'h1;
    cmd_write <= f[2];
    cmd_burst <= f[1];
    cmd_global <= f[0];
    cmd_lanes <= ln;
    cmd_addr <= a;
    wr_data <= d;
    @(negedge clk_sys);
    while (cmd_ready !== 1'h1)
    begin
      n++;
      if (n > 40)
        give_up();
      @(negedge clk_sys);
    end
    `CHK(wr_take, f[2])
    @(posedge clk_sys);
    if (!keep)
      cmd_valid <= 1'h0;
    // beats follow the counter order; the model is updated as each beat goes out
    for (int k = 0; k < (f[1] ? SBSP_BURST_LEN : 1); k++)
    begin
      dk = d + k;
      ba = a;
      ba[1:0] = lin ? a[1:0] + k[1:0] : a[1:0] ^ k[1:0];
      if (f[2] && k > 0)
      begin
        wr_data <= dk;
        @(negedge clk_sys);
        `CHK(wr_take, 1'h1)
        @(posedge clk_sys);
      end
      for (int l = 0; l < SBSP_LANES; l++)
        if (f[2] && (f[0] || ln[l]))
          mem[ba[5:0]][lane_w*l+:lane_w] = dk[lane_w*l+:lane_w];
      if (!f[2])
      begin
        xq.push_back(mem[ba[5:0]]);
        // cyc here and in the beat monitor is read before its own edge's update
        tq.push_back(cyc + lat + 2 + k);
      end
    end
    if (!keep)
      @(posedge clk_sys);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (xq.size() > 0)
    begin
      n++;
      if (n > 40)
        give_up();
      @(posedge clk_sys);
    end
    repeat (3) @(posedge clk_sys);
  endtask

  // modes only change while nothing is in flight
  task automatic set_modes(input logic lin, input logic pipe, input logic drv);
    drain();
    mode_linear <= lin;
    mode_pipeline <= pipe;
    mode_drive <= drv;
    repeat (4) @(posedge clk_sys);
  endtask

  // every read beat is compared in value and in arrival edge
  always @(posedge clk_sys)
  begin
    if (rd_valid === 1'h1)
    begin
      if (xq.size() == 0)
      begin
        miscompares++;
        $display("ERROR at %0t: read beat not expected", $time);
      end
      else
      begin
        exp_d = xq.pop_front();
        exp_t = tq.pop_front();
        `CHK(rd_data, exp_d)
        `CHK(cyc, exp_t)
      end
    end
  end

  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'h1;
    @(posedge clk_sys);
    // global write ignores the lane selects, then byte write touches lanes 0 and 2 only
    issue(3'h5, 4'h0, 19'h10, 36'h123456789, 1'h0);
    issue(3'h0, 4'h0, 19'h10, 36'h0, 1'h0);
    issue(3'h4, 4'h5, 19'h10, 36'hfedcba987, 1'h0);
    issue(3'h0, 4'h0, 19'h10, 36'h0, 1'h0);
    // burst write from an odd start wraps in the group; singles read back every cycle
    issue(3'h7, 4'h0, 19'h21, 36'ha00000000, 1'h0);
    for (int i = 0; i < 4; i++)
      issue(3'h0, 4'h0, 19'h20 + i, 36'h0, i < 3);
    drain();
    `CHK(burst_lsbs, 2'h3)
    set_modes(1'h0, 1'h1, 1'h1);
    issue(3'h2, 4'h0, 19'h21, 36'h0, 1'h0);
    set_modes(1'h1, 1'h0, 1'h1);
    issue(3'h2, 4'h0, 19'h23, 36'h0, 1'h0);
    drain();
    // sleep holds off commands and drive, and the contents survive it
    sleep_req <= 1'h1;
    repeat (4) @(posedge clk_sys);
    `CHK(asleep, 1'h1)
    `CHK(cmd_ready, 1'h0)
    `CHK(u_sbsp_if.dq_d_oe, 1'h0)
    sleep_req <= 1'h0;
    repeat (4) @(posedge clk_sys);
    `CHK(asleep, 1'h0)
    issue(3'h0, 4'h0, 19'h10, 36'h0, 1'h0);
    // open mode pins: pipelined, interleaved
    set_modes(1'h1, 1'h0, 1'h0);
    `CHK(pipelined, SBSP_PULL_FT_N)
    issue(3'h2, 4'h0, 19'h22, 36'h0, 1'h0);
    drain();
    report_and_stop();
  end
endmodule
